/* vss_cfg.svh */
// register indices, field positions, reset values and counts of the sync sampler
`ifndef VSS_CFG_SVH
`define VSS_CFG_SVH

// ==========================================================
// register indices, byte address is four times the index
`define VSS_IDX_CTRL    8'h21
`define VSS_IDX_VOFF    8'h22
`define VSS_IDX_HOFF    8'h23
`define VSS_IDX_VLEN    8'h24
`define VSS_IDX_HLEN_LO 8'h29
`define VSS_IDX_HLEN_HI 8'h2A
`define VSS_IDX_CLAMP   8'h2B
`define VSS_IDX_GAIN    8'h2D
`define VSS_IDX_STAT    8'h2F

// ==========================================================
// status fields
`define VSS_STAT_OVF    0
`define VSS_STAT_VWIN   1
`define VSS_STAT_HWIN   2
`define VSS_STAT_RDY    3
`define VSS_STAT_LINE   16

// ==========================================================
// reset values
`define VSS_CTRL_RST    6'h00
`define VSS_VOFF_RST    11'h000
`define VSS_HOFF_RST    12'h000
`define VSS_VLEN_RST    11'h7FF
`define VSS_HLEN_RST    12'hFFF
`define VSS_DLY_RST     8'h00

// ==========================================================
// counts and widths
`define VSS_CLAMP_W     8'h10
`define VSS_GAIN_W      8'h10
`define VSS_DW          24
`define VSS_FIFO_DEPTH  16

`endif

/* vss_pkg.sv */
// types of the sync sampler
`include "vss_cfg.svh"
package vss_pkg;

  // control register layout, bit 5 downward
  typedef struct packed {
    logic en;
    logic adcSeq;
    logic gainPol;
    logic clampPol;
    logic vPol;
    logic hPol;
  } vss_ctrl_t;

  // one sampled pixel
  typedef struct packed {
    logic                adcSel;
    logic [`VSS_DW-1:0]  data;
  } vss_pix_t;

  // pulse generator states
  typedef enum logic [1:0] {
    PS_IDLE   = 2'b00,
    PS_DELAY  = 2'b01,
    PS_ACTIVE = 2'b10
  } vss_pstate_t;

endpackage : vss_pkg

/* vss_fifo.sv */
// pixel fifo with registered read data
`timescale 1ns/10ps
`include "vss_cfg.svh"
module vss_fifo #(
  parameter int WIDTH = 25,
  parameter int DEPTH = `VSS_FIFO_DEPTH
) (
  // clock and reset
  input  wire logic             mclk,
  input  wire logic             reset_n,
  // fill side
  input  wire logic             inValid,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  inReady,
  // drain side
  output logic                  outValid,
  output logic [WIDTH-1:0]      outData,
  input  wire logic             outReady
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wrPtr_r, rdPtr_r;
  logic [AW:0]      cnt_r, cnt_nxt;
  logic             inReady_r, outValid_r;
  logic [WIDTH-1:0] outData_r;
  logic             wr, pop;

  assign wr       = inValid && inReady_r;
  assign pop      = (cnt_r != '0) && (!outValid_r || outReady);
  assign cnt_nxt  = cnt_r + {{AW{1'b0}}, wr} - {{AW{1'b0}}, pop};
  assign inReady  = inReady_r;
  assign outValid = outValid_r;
  assign outData  = outData_r;

  // ==========================================================
  // storage
  always_ff @(posedge mclk) begin
    if (wr) begin
      mem_r[wrPtr_r] <= inData;
    end
  end

  // ==========================================================
  // pointers and fill level
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      wrPtr_r   <= '0;
      rdPtr_r   <= '0;
      cnt_r     <= '0;
      inReady_r <= 1'b1;
    end else begin
      if (wr) begin
        wrPtr_r <= (wrPtr_r == AW'(DEPTH - 1)) ? '0 : wrPtr_r + AW'(1);
      end
      if (pop) begin
        rdPtr_r <= (rdPtr_r == AW'(DEPTH - 1)) ? '0 : rdPtr_r + AW'(1);
      end
      cnt_r     <= cnt_nxt;
      inReady_r <= cnt_nxt < (AW+1)'(DEPTH);
    end
  end

  // ==========================================================
  // output register
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      outValid_r <= 1'b0;
      outData_r  <= '0;
    end else if (pop) begin
      outValid_r <= 1'b1;
      outData_r  <= mem_r[rdPtr_r];
    end else if (outReady) begin
      outValid_r <= 1'b0;
    end
  end

endmodule : vss_fifo

/* vss_sampler.sv */
// video sync sampler: apb registers, sync edges, sampling window, pulses
`timescale 1ns/10ps
`include "vss_cfg.svh"
module vss_sampler #(
  parameter int         FIFO_DEPTH  = `VSS_FIFO_DEPTH,
  parameter logic [7:0] CLAMP_WIDTH = `VSS_CLAMP_W,
  parameter logic [7:0] GAIN_WIDTH  = `VSS_GAIN_W
) (
  // clock and reset
  input  wire logic               mclk,
  input  wire logic               reset_n,
  // apb slave
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [11:0]        paddr,
  input  wire logic [31:0]        pwdata,
  output logic [31:0]             prdata,
  output logic                    pready,
  output logic                    pslverr,
  // sync inputs
  input  wire logic               hsyncPin,
  input  wire logic               vsyncPin,
  // adc data
  input  wire logic [`VSS_DW-1:0] adc0Data,
  input  wire logic [`VSS_DW-1:0] adc1Data,
  // pulses to the adcs
  output logic                    clampPulse,
  output logic                    gainCorrectionPulse,
  // pixel stream
  output logic                    pixValid,
  output vss_pkg::vss_pix_t       pixData,
  input  wire logic               pixReady,
  output logic                    sampleReady
);
  import vss_pkg::*;

  // ==========================================================
  // declarations
  vss_ctrl_t   ctrl_r;
  logic [10:0] vOff_r, vLen_r, lineCnt_r;
  logic [11:0] hOff_r, hLen_r, pixCnt_r;
  logic [7:0]  clampStart_r, gainStart_r;
  logic        overflow_r;
  logic        hsPrev_r, vsPrev_r;
  logic        syncSeen_r;
  logic        lineStart, syncLead, frameStart;
  logic [12:0] hRel;
  logic [11:0] vRel;
  logic        vWin, hWin, doSample, fifoReady;
  logic        adcSel_r;
  vss_pix_t    sampleWord;
  logic [7:0]  regIdx;
  logic        apbSetup, apbWrite, rdHit;
  logic [31:0] rdVal, prdata_r;
  logic        pready_r, pslverr_r;
  logic [1:0]  pTrig, pPol, pulseOut_r;
  logic [7:0]  pDly [2];
  logic [7:0]  pWid [2];
  logic [7:0]  pCnt_r [2];
  vss_pstate_t pSt_r [2];

  assign prdata              = prdata_r;
  assign pready              = pready_r;
  assign pslverr             = pslverr_r;
  assign clampPulse          = pulseOut_r[0];
  assign gainCorrectionPulse = pulseOut_r[1];
  assign sampleReady         = fifoReady;

  // ==========================================================
  // apb slave, zero wait states
  assign regIdx   = paddr[9:2];
  assign apbSetup = psel && !penable;
  assign apbWrite = psel && penable && pready_r && pwrite && rdHit;

  always_comb begin
    rdVal = 32'h0000_0000;
    rdHit = (paddr[11:10] == 2'h0);
    case (regIdx)
      `VSS_IDX_CTRL:    rdVal[5:0]  = ctrl_r;
      `VSS_IDX_VOFF:    rdVal[10:0] = vOff_r;
      `VSS_IDX_HOFF:    rdVal[11:0] = hOff_r;
      `VSS_IDX_VLEN:    rdVal[10:0] = vLen_r;
      `VSS_IDX_HLEN_LO: rdVal[7:0]  = hLen_r[7:0];
      `VSS_IDX_HLEN_HI: rdVal[3:0]  = hLen_r[11:8];
      `VSS_IDX_CLAMP:   rdVal[7:0]  = clampStart_r;
      `VSS_IDX_GAIN:    rdVal[7:0]  = gainStart_r;
      `VSS_IDX_STAT: begin
        rdVal[`VSS_STAT_OVF]                    = overflow_r;
        rdVal[`VSS_STAT_VWIN]                   = vWin;
        rdVal[`VSS_STAT_HWIN]                   = hWin;
        rdVal[`VSS_STAT_RDY]                    = fifoReady;
        rdVal[`VSS_STAT_LINE+10:`VSS_STAT_LINE] = lineCnt_r;
      end
      default:          rdHit = 1'b0;
    endcase
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0000_0000;
    end else begin
      pready_r  <= apbSetup;
      pslverr_r <= apbSetup && !rdHit;
      prdata_r  <= (apbSetup && !pwrite) ? rdVal : 32'h0000_0000;
    end
  end

  // ==========================================================
  // configuration registers
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_r       <= `VSS_CTRL_RST;
      vOff_r       <= `VSS_VOFF_RST;
      hOff_r       <= `VSS_HOFF_RST;
      vLen_r       <= `VSS_VLEN_RST;
      hLen_r       <= `VSS_HLEN_RST;
      clampStart_r <= `VSS_DLY_RST;
      gainStart_r  <= `VSS_DLY_RST;
    end else if (apbWrite) begin
      case (regIdx)
        `VSS_IDX_CTRL:    ctrl_r        <= pwdata[5:0];
        `VSS_IDX_VOFF:    vOff_r        <= pwdata[10:0];
        `VSS_IDX_HOFF:    hOff_r        <= pwdata[11:0];
        `VSS_IDX_VLEN:    vLen_r        <= pwdata[10:0];
        `VSS_IDX_HLEN_LO: hLen_r[7:0]   <= pwdata[7:0];
        `VSS_IDX_HLEN_HI: hLen_r[11:8]  <= pwdata[3:0];
        `VSS_IDX_CLAMP:   clampStart_r  <= pwdata[7:0];
        `VSS_IDX_GAIN:    gainStart_r   <= pwdata[7:0];
        default: ;
      endcase
    end
  end

  // ==========================================================
  // sync edge detection
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      hsPrev_r   <= 1'b0;
      vsPrev_r   <= 1'b0;
      syncSeen_r <= 1'b0;
    end else begin
      hsPrev_r   <= hsyncPin;
      vsPrev_r   <= vsyncPin;
      syncSeen_r <= 1'b1;
    end
  end

  // line start on trailing edge of the sync pulse
  // no edge before the pins were sampled once, avoids a false edge after reset
  assign lineStart  = syncSeen_r && (ctrl_r.hPol ? (hsPrev_r && !hsyncPin)
                                                 : (!hsPrev_r && hsyncPin));
  assign syncLead   = syncSeen_r && (ctrl_r.hPol ? (!hsPrev_r && hsyncPin)
                                                 : (hsPrev_r && !hsyncPin));
  assign frameStart = syncSeen_r && (ctrl_r.vPol ? (vsPrev_r && !vsyncPin)
                                                 : (!vsPrev_r && vsyncPin));

  // ==========================================================
  // pixel and line counters, saturating
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      pixCnt_r <= 12'hFFF;
    end else if (lineStart) begin
      pixCnt_r <= 12'h000;
    end else if (pixCnt_r != 12'hFFF) begin
      pixCnt_r <= pixCnt_r + 12'h001;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      lineCnt_r <= 11'h7FF;
    end else if (frameStart) begin
      lineCnt_r <= 11'h000;
    end else if (lineStart && lineCnt_r != 11'h7FF) begin
      lineCnt_r <= lineCnt_r + 11'h001;
    end
  end

  // ==========================================================
  // sampling window
  assign hRel = {1'b0, pixCnt_r} - {1'b0, hOff_r};
  assign vRel = {1'b0, lineCnt_r} - {1'b0, vOff_r};
  assign hWin = (pixCnt_r >= hOff_r) && (hRel[11:0] < hLen_r);
  assign vWin = (lineCnt_r >= vOff_r) && (vRel[10:0] < vLen_r);
  assign doSample = ctrl_r.en && vWin && hWin && !lineStart;

  // adc interleave restarts at each line
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      adcSel_r <= 1'b0;
    end else if (lineStart) begin
      adcSel_r <= ctrl_r.adcSeq;
    end else if (doSample && fifoReady) begin
      adcSel_r <= !adcSel_r;
    end
  end

  assign sampleWord.adcSel = adcSel_r;
  assign sampleWord.data   = adcSel_r ? adc1Data : adc0Data;

  // lost sample flag, set wins over clear
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      overflow_r <= 1'b0;
    end else if (doSample && !fifoReady) begin
      overflow_r <= 1'b1;
    end else if (apbWrite && regIdx == `VSS_IDX_STAT && pwdata[`VSS_STAT_OVF]) begin
      overflow_r <= 1'b0;
    end
  end

  vss_fifo #(
    .WIDTH ($bits(vss_pix_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .mclk     (mclk),
    .reset_n  (reset_n),
    .inValid  (doSample),
    .inData   (sampleWord),
    .inReady  (fifoReady),
    .outValid (pixValid),
    .outData  (pixData),
    .outReady (pixReady)
  );

  // ==========================================================
  // clamp (0) and gain correction (1) pulse generators
  assign pTrig   = {syncLead, lineStart};
  assign pPol    = {ctrl_r.gainPol, ctrl_r.clampPol};
  assign pDly[0] = clampStart_r;
  assign pDly[1] = gainStart_r;
  assign pWid[0] = CLAMP_WIDTH;
  assign pWid[1] = GAIN_WIDTH;

  for (genvar i = 0; i < 2; i++) begin : g_pulse
    always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
        pSt_r[i]  <= PS_IDLE;
        pCnt_r[i] <= 8'h00;
      end else if (pTrig[i]) begin
        pSt_r[i]  <= PS_DELAY;
        pCnt_r[i] <= pDly[i];
      end else begin
        case (pSt_r[i])
          PS_DELAY: begin
            if (pCnt_r[i] == 8'h00) begin
              pSt_r[i]  <= PS_ACTIVE;
              pCnt_r[i] <= pWid[i] - 8'h01;
            end else begin
              pCnt_r[i] <= pCnt_r[i] - 8'h01;
            end
          end
          PS_ACTIVE: begin
            if (pCnt_r[i] == 8'h00) begin
              pSt_r[i] <= PS_IDLE;
            end else begin
              pCnt_r[i] <= pCnt_r[i] - 8'h01;
            end
          end
          default: pSt_r[i] <= PS_IDLE;
        endcase
      end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
        pulseOut_r[i] <= 1'b1;
      end else begin
        pulseOut_r[i] <= (pSt_r[i] == PS_ACTIVE) ? pPol[i] : !pPol[i];
      end
    end
  end

  // ==========================================================
  // checks
  a_hsync_low_edge: assert property (@(posedge mclk) disable iff (!reset_n)
    (!ctrl_r.hPol && $rose(hsyncPin)) |=> pixCnt_r == 12'h000)
    else $error("line start missed on rising hsync");

  a_vsync_high_ref: assert property (@(posedge mclk) disable iff (!reset_n)
    (ctrl_r.vPol && $fell(vsyncPin)) |=> lineCnt_r == 11'h000)
    else $error("frame reference missed on falling vsync");

  a_vsync_low_ref: assert property (@(posedge mclk) disable iff (!reset_n)
    (!ctrl_r.vPol && $rose(vsyncPin)) |=> lineCnt_r == 11'h000)
    else $error("frame reference missed on rising vsync");

  a_clamp_level: assert property (@(posedge mclk) disable iff (!reset_n)
    (pSt_r[0] == PS_ACTIVE) |=> clampPulse == $past(ctrl_r.clampPol))
    else $error("clamp pulse level wrong");

  a_gain_level: assert property (@(posedge mclk) disable iff (!reset_n)
    (pSt_r[1] == PS_IDLE) |=> gainCorrectionPulse == !$past(ctrl_r.gainPol))
    else $error("gain pulse idle level wrong");

  a_adc_first: assert property (@(posedge mclk) disable iff (!reset_n)
    lineStart |=> adcSel_r == $past(ctrl_r.adcSeq))
    else $error("wrong adc first after line start");

  a_sample_gate: assert property (@(posedge mclk) disable iff (!reset_n)
    (!ctrl_r.en && !lineStart) |=> $stable(adcSel_r))
    else $error("sample taken while disabled");

  a_vert_window: assert property (@(posedge mclk) disable iff (!reset_n)
    doSample |-> (lineCnt_r >= vOff_r && ({1'b0, lineCnt_r} < {1'b0, vOff_r} + {1'b0, vLen_r})))
    else $error("sample outside vertical window");

  a_horz_window: assert property (@(posedge mclk) disable iff (!reset_n)
    doSample |-> (pixCnt_r >= hOff_r && ({1'b0, pixCnt_r} < {1'b0, hOff_r} + {1'b0, hLen_r})))
    else $error("sample outside horizontal window");

  a_clamp_delay: assert property (@(posedge mclk) disable iff (!reset_n)
    pTrig[0] |=> (pSt_r[0] == PS_DELAY && pCnt_r[0] == $past(clampStart_r)))
    else $error("clamp delay not loaded");

  a_gain_delay: assert property (@(posedge mclk) disable iff (!reset_n)
    (pTrig[1] && gainStart_r == 8'h00 && !ctrl_r.hPol && !ctrl_r.gainPol)
      ##1 !pTrig[1] |=> ##1 !gainCorrectionPulse)
    else $error("gain pulse late for zero delay");

  a_apb_answer: assert property (@(posedge mclk) disable iff (!reset_n)
    (psel && !penable) |=> pready)
    else $error("apb access not answered in one cycle");

endmodule : vss_sampler

/* vss_video_src.sv */
// behavioural sync source and adc pair facing the sampler
`timescale 1ns/10ps
`include "vss_cfg.svh"
module vss_video_src (
  // clock
  input  wire logic          mclk,
  // frame control
  input  wire logic          go,
  input  wire logic          hPol,
  input  wire logic          vPol,
  input  wire logic [7:0]    noise,
  output logic               busy,
  // pins toward the sampler
  output logic               hsyncPin,
  output logic               vsyncPin,
  output logic [`VSS_DW-1:0] adc0Data,
  output logic [`VSS_DW-1:0] adc1Data
);
  logic [7:0] pos;

  // top byte names the adc, low byte is the position in the line
  assign adc0Data = {8'hA0, noise, pos};
  assign adc1Data = {8'hB1, noise, pos};

  initial begin
    busy     = 1'b0;
    hsyncPin = 1'b1;
    vsyncPin = 1'b1;
    pos      = 8'h00;
  end

  // 4 cycles of sync, then 36 cycles of video
  task automatic line();
    repeat (4) begin
      @(posedge mclk);
      hsyncPin <= hPol;
    end
    for (int i = 0; i < 36; i++) begin
      @(posedge mclk);
      hsyncPin <= ~hPol;
      pos      <= i[7:0];
    end
  endtask : line

  // vsync spans one line so a wrong reference edge shifts the count
  always begin
    @(posedge mclk);
    if (go === 1'b1) begin
      busy     <= 1'b1;
      vsyncPin <= vPol;
      line();
      vsyncPin <= ~vPol;
      repeat (4) line();
      busy <= 1'b0;
    end else begin
      hsyncPin <= ~hPol;
      vsyncPin <= ~vPol;
    end
  end
endmodule : vss_video_src

/* tb_vss_sampler.sv */
// self-checking bench of the video sync sampler
`timescale 1ns/10ps
`include "vss_cfg.svh"
module tb_vss_sampler;
  import vss_pkg::*;
  logic               mclk, reset_n, psel, penable, pwrite, pready, pslverr;
  logic [11:0]        paddr;
  logic [31:0]        pwdata, prdata, seed, rd, wv;
  logic               hsyncPin, vsyncPin, clampPulse, gainCorrectionPulse;
  logic [`VSS_DW-1:0] adc0Data, adc1Data;
  logic               pixValid, pixReady, sampleReady, go, busy, hPol, vPol;
  logic               clampPol, gainPol, hsPrev, cpPrev, gpPrev, sawFull, err;
  vss_pix_t           pixData;
  vss_pix_t           pixQ[$];
  logic [7:0]         noise, firstA, firstB;
  logic [1:0]         rdyMode;
  int                 error_cnt, comparisons, cyc, hTrail, hLead, lat0;
  int                 clampStart, gainStart, clampW, gainW, cwCnt, gwCnt;

  vss_sampler dut (.mclk(mclk), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .hsyncPin(hsyncPin), .vsyncPin(vsyncPin), .adc0Data(adc0Data),
    .adc1Data(adc1Data), .clampPulse(clampPulse), .gainCorrectionPulse(gainCorrectionPulse),
    .pixValid(pixValid), .pixData(pixData), .pixReady(pixReady), .sampleReady(sampleReady));
  vss_video_src src (.mclk(mclk), .go(go), .hPol(hPol), .vPol(vPol), .noise(noise),
    .busy(busy), .hsyncPin(hsyncPin), .vsyncPin(vsyncPin), .adc0Data(adc0Data),
    .adc1Data(adc1Data));

  always #2.5 mclk = ~mclk;

  // ==========================================================
  // helpers
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs

  // adc select restarts at each line start, then alternates
  function automatic logic exp_sel(input logic seq, input int k, input int hl);
    return seq ^ ((k % hl) % 2 == 1);
  endfunction : exp_sel

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
    @(posedge mclk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= {2'b00, idx, 2'b00};
    pwdata <= wd;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1) @(posedge mclk);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic cfg(input vss_ctrl_t c, input logic [10:0] vo, input logic [10:0] vl,
                     input logic [11:0] ho, input logic [11:0] hl, input logic [7:0] cd,
                     input logic [7:0] gd);
    apb(1'b1, `VSS_IDX_CTRL, {26'h0, c});
    apb(1'b1, `VSS_IDX_VOFF, {21'h0, vo});
    apb(1'b1, `VSS_IDX_VLEN, {21'h0, vl});
    apb(1'b1, `VSS_IDX_HOFF, {20'h0, ho});
    apb(1'b1, `VSS_IDX_HLEN_LO, {24'h0, hl[7:0]});
    apb(1'b1, `VSS_IDX_HLEN_HI, {28'h0, hl[11:8]});
    apb(1'b1, `VSS_IDX_CLAMP, {24'h0, cd});
    apb(1'b1, `VSS_IDX_GAIN, {24'h0, gd});
    hPol     <= c.hPol;
    vPol     <= c.vPol;
    clampPol <= c.clampPol;
    gainPol  <= c.gainPol;
  endtask : cfg

  task automatic run_frame();
    go <= 1'b1;
    @(posedge mclk);
    go <= 1'b0;
    repeat (2) @(posedge mclk);
    while (busy !== 1'b0) @(posedge mclk);
    repeat (30) @(posedge mclk);
  endtask : run_frame

  task automatic chk_pix(input int n, input int hl, input logic seq, output logic [7:0] fp);
    vss_pix_t p;
    chk(32'(pixQ.size()), 32'(n * hl));
    fp = (pixQ.size() > 0) ? pixQ[0].data[7:0] : 8'h00;
    for (int i = 0; i < pixQ.size(); i++) begin
      p = pixQ[i];
      chk(p.adcSel, exp_sel(seq, i, hl));
      chk(p.data[23:16], p.adcSel ? 8'hB1 : 8'hA0);
      chk(p.data[7:0], fp + 8'(i % hl));
    end
    pixQ.delete();
  endtask : chk_pix

  task automatic print_verdict();
    $display("comparisons %0d, errors %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : print_verdict

  // ==========================================================
  // monitor: pixel capture, sync edges, pulse start and width
  always @(posedge mclk) begin
    cyc   <= cyc + 1;
    noise <= 8'(xs());
    pixReady <= (rdyMode == 2'd2) | ((rdyMode == 2'd1) & seed[9]);
    if (pixValid === 1'b1 && pixReady === 1'b1) pixQ.push_back(pixData);
    if (sampleReady === 1'b0) sawFull <= 1'b1;
    if (hsyncPin !== hsPrev) begin
      if (hsyncPin === hPol) hLead <= cyc;
      else hTrail <= cyc;
    end
    hsPrev <= hsyncPin;
    if (clampPulse === clampPol) begin
      if (cpPrev !== clampPol) clampStart <= cyc;
      cwCnt <= cwCnt + 1;
    end else if (cwCnt != 0) begin
      clampW <= cwCnt;
      cwCnt  <= 0;
    end
    if (gainCorrectionPulse === gainPol) begin
      if (gpPrev !== gainPol) gainStart <= cyc;
      gwCnt <= gwCnt + 1;
    end else if (gwCnt != 0) begin
      gainW <= gwCnt;
      gwCnt <= 0;
    end
    cpPrev <= clampPulse;
    gpPrev <= gainCorrectionPulse;
  end

  initial begin
    #100000;
    error_cnt++;
    print_verdict();
  end

  // ==========================================================
  // main sequence
  initial begin
    {mclk, reset_n, psel, penable, pwrite, go, hPol, vPol} = '0;
    {clampPol, gainPol, rdyMode} = '0;
    {paddr, pwdata, wv} = '0;
    seed = 32'd31;
    repeat (5) @(posedge mclk);
    chk(clampPulse, 1'b1);
    chk(gainCorrectionPulse, 1'b1);
    chk(sampleReady, 1'b1);
    chk(pixValid, 1'b0);
    reset_n <= 1'b1;
    apb(1'b0, `VSS_IDX_VLEN, 32'h0);
    chk(rd, 32'h7FF);
    apb(1'b0, `VSS_IDX_HLEN_LO, 32'h0);
    chk(rd, 32'hFF);
    apb(1'b0, `VSS_IDX_HLEN_HI, 32'h0);
    chk(rd, 32'hF);
    apb(1'b0, `VSS_IDX_CTRL, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 8'h30, 32'h0);
    chk(err, 1'b1);
    chk(rd, 32'h0);
    for (int i = 0; i < 4; i++) begin
      wv = xs();
      apb(1'b1, `VSS_IDX_HLEN_HI, wv);
      apb(1'b0, `VSS_IDX_HLEN_HI, 32'h0);
      chk(rd, {28'h0, wv[3:0]});
      apb(1'b1, `VSS_IDX_CLAMP, wv);
      apb(1'b0, `VSS_IDX_CLAMP, 32'h0);
      chk(rd, {24'h0, wv[7:0]});
    end
    rdyMode <= 2'd1;
    cfg('{en:1, adcSeq:0, gainPol:0, clampPol:0, vPol:0, hPol:0}, 1, 2, 2, 5, 0, 0);
    run_frame();
    chk_pix(2, 5, 1'b0, firstA);
    lat0 = clampStart - hTrail;
    chk(gainStart - hLead, lat0);
    chk(clampW, 16);
    chk(gainW, 16);
    cfg('{en:1, adcSeq:1, gainPol:1, clampPol:1, vPol:1, hPol:1}, 2, 3, 7, 5, 5, 3);
    run_frame();
    chk_pix(3, 5, 1'b1, firstB);
    chk(firstB, firstA + 8'd5);
    chk(clampStart - hTrail, lat0 + 5);
    chk(gainStart - hLead, lat0 + 3);
    chk(clampW, 16);
    chk(gainW, 16);
    chk({clampPulse, gainCorrectionPulse}, 2'b00);
    cfg('{en:0, adcSeq:1, gainPol:1, clampPol:1, vPol:1, hPol:1}, 1, 3, 2, 5, 0, 0);
    run_frame();
    chk_pix(0, 5, 1'b0, firstB);
    rdyMode <= 2'd0;
    cfg('{en:1, adcSeq:0, gainPol:1, clampPol:1, vPol:1, hPol:1}, 1, 1, 2, 30, 0, 0);
    run_frame();
    chk(sawFull, 1'b1);
    apb(1'b0, `VSS_IDX_STAT, 32'h0);
    chk(rd[`VSS_STAT_OVF], 1'b1);
    apb(1'b1, `VSS_IDX_STAT, 32'h1);
    apb(1'b0, `VSS_IDX_STAT, 32'h0);
    chk(rd[`VSS_STAT_OVF], 1'b0);
    rdyMode <= 2'd2;
    repeat (40) @(posedge mclk);
    chk(pixQ.size() >= `VSS_FIFO_DEPTH, 1'b1);
    chk(pixValid, 1'b0);
    print_verdict();
  end
endmodule : tb_vss_sampler
